// [logic/csw_pkg.sv]
// constants and types for the charge safety and host watchdog block
package csw_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  // prescaler: one tick every 1 us
  localparam int unsigned TICK_NS         = 1000;
  localparam int unsigned TICK_CYC        = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned PULSE_US        = 128;
  localparam int unsigned PULSE_TICKS     = PULSE_US * 1000 / TICK_NS;
  localparam int unsigned WDOG_S          = 50;
  localparam int unsigned WDOG_TICKS      = WDOG_S * 1_000_000;
  // one safety-timer step per unit of the duration field: 1 hour
  localparam int unsigned HOUR_S          = 3600;
  localparam int unsigned SAFE_UNIT_TICKS = HOUR_S * 1_000_000;
  localparam int unsigned PRECHG_DIV      = 10;
  // input limit code: 50 mA per step, code 0 = 50 mA, code 7 = 400 mA
  localparam int unsigned INPUT_LIMIT_RESISTOR_PIN_STEP_MA    = 50;
  localparam logic [2:0]  INPUT_LIMIT_RESISTOR_PIN_DEF        = 3'h1;
  localparam logic [7:0]  ICHG_DEF        = 8'h0a;
  localparam logic [1:0]  DUR_DEF         = 2'h1;
  localparam logic        DTE_DEF         = 1'b0;
  localparam logic        CEN_N_DEF       = 1'b1;

  typedef enum logic [1:0] {
    CSW_IDLE  = 2'b00,
    CSW_PRE   = 2'b01,
    CSW_FAST  = 2'b10,
    CSW_FAULT = 2'b11
  } csw_state_e;
endpackage

// [logic/csw_top.sv]
// charge safety timer, host watchdog and current-setting source selection
`timescale 1ns/1ps
module csw_top #(
  parameter int unsigned WDOG_TICKS_P = csw_pkg::WDOG_TICKS,
  parameter int unsigned SAFE_UNIT_P  = csw_pkg::SAFE_UNIT_TICKS
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_host_txn,
  input  wire logic       i_host_wr,
  input  wire logic [2:0] i_wr_input_limit_resistor_pin_code,
  input  wire logic [7:0] i_wr_ichg_code,
  input  wire logic [1:0] i_wr_duration,
  input  wire logic       i_wr_double_time,
  input  wire logic       i_wr_charge_en_n,
  input  wire logic       i_wr_pb_fields,
  input  wire logic [3:0] i_wr_pb_value,
  input  wire logic       i_input_limit_resistor_pin_gnd,
  input  wire logic [2:0] i_input_limit_resistor_code,
  input  wire logic       i_charge_current_resistor_pin_gnd,
  input  wire logic [7:0] i_charge_current_resistor_code,
  input  wire logic       i_charge_disable_pin,
  input  wire logic       i_vin_valid,
  input  wire logic       i_hiz_mode,
  input  wire logic       i_terminated,
  input  wire logic       i_loop_cc_cv,
  input  wire logic       i_batt_low,
  output logic [2:0]      o_input_limit_resistor_pin_code,
  output logic            o_input_limit_resistor_pin_external,
  output logic [7:0]      o_ichg_code,
  output logic            o_ichg_external,
  output logic            o_charging,
  output logic [1:0]      o_state,
  output logic            o_fault,
  output logic            o_int_pulse,
  output logic            o_host_mode,
  output logic            o_wdog_expired,
  output logic [3:0]      o_pb_fields
);

  logic [9:0]       tick_cnt_r;
  logic             tick_r;
  logic             half_r;
  logic             host_mode_r;
  logic [2:0]       input_limit_resistor_pin_reg_r;
  logic [7:0]       ichg_reg_r;
  logic [1:0]       dur_r;
  logic             dte_r;
  logic             cen_n_r;
  logic [3:0]       pb_r;
  logic             wd_run_r;
  logic [31:0]      wd_cnt_r;
  logic             wd_exp_r;
  csw_pkg::csw_state_e state_r;
  logic [35:0]      safe_cnt_r;
  logic [35:0]      safe_lim;
  logic             ok_prev_r;
  logic [7:0]       pulse_cnt_r;
  logic             fault_r;
  logic [2:0]       input_limit_resistor_pin_out_r;
  logic [7:0]       ichg_out_r;
  logic             step;
  logic             dur_change;
  logic             charge_ok;

  // 1 us prescaler
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_r <= 10'h000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 10'(csw_pkg::TICK_CYC - 1)) begin
      tick_cnt_r <= 10'h000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 10'h001;
      tick_r     <= 1'b0;
    end
  end

  // host mode entry on any write, cleared by watchdog expiry
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      host_mode_r <= 1'b0;
    end else if (i_host_txn && i_host_wr) begin
      host_mode_r <= 1'b1;
    end else if (wd_exp_r) begin
      host_mode_r <= 1'b0;
    end
  end

  // register image; expiry restores defaults, a write in the expiry cycle wins like host mode
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      input_limit_resistor_pin_reg_r <= csw_pkg::INPUT_LIMIT_RESISTOR_PIN_DEF;
      ichg_reg_r <= csw_pkg::ICHG_DEF;
      dur_r      <= csw_pkg::DUR_DEF;
      dte_r      <= csw_pkg::DTE_DEF;
      cen_n_r    <= csw_pkg::CEN_N_DEF;
    end else if (i_host_txn && i_host_wr) begin
      input_limit_resistor_pin_reg_r <= i_wr_input_limit_resistor_pin_code;
      ichg_reg_r <= i_wr_ichg_code;
      dur_r      <= i_wr_duration;
      dte_r      <= i_wr_double_time;
      cen_n_r    <= i_wr_charge_en_n;
    end else if (wd_exp_r) begin
      input_limit_resistor_pin_reg_r <= csw_pkg::INPUT_LIMIT_RESISTOR_PIN_DEF;
      ichg_reg_r <= csw_pkg::ICHG_DEF;
      dur_r      <= csw_pkg::DUR_DEF;
      dte_r      <= csw_pkg::DTE_DEF;
      cen_n_r    <= csw_pkg::CEN_N_DEF;
    end
  end

  // pushbutton fields survive watchdog expiry
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pb_r <= 4'h0;
    end else if (i_host_txn && i_host_wr && i_wr_pb_fields) begin
      pb_r <= i_wr_pb_value;
    end
  end

  // current setting source
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      input_limit_resistor_pin_out_r      <= csw_pkg::INPUT_LIMIT_RESISTOR_PIN_DEF;
      o_input_limit_resistor_pin_external <= 1'b0;
      ichg_out_r      <= csw_pkg::ICHG_DEF;
      o_ichg_external <= 1'b0;
    end else begin
      if (host_mode_r || i_input_limit_resistor_pin_gnd) begin
        input_limit_resistor_pin_out_r      <= input_limit_resistor_pin_reg_r;
        o_input_limit_resistor_pin_external <= 1'b0;
      end else begin
        input_limit_resistor_pin_out_r      <= i_input_limit_resistor_code;
        o_input_limit_resistor_pin_external <= 1'b1;
      end
      if (host_mode_r || i_charge_current_resistor_pin_gnd) begin
        ichg_out_r      <= ichg_reg_r;
        o_ichg_external <= 1'b0;
      end else begin
        ichg_out_r      <= i_charge_current_resistor_code;
        o_ichg_external <= 1'b1;
      end
    end
  end

  // watchdog: armed by a transaction, cleared by high impedance mode
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wd_run_r <= 1'b0;
      wd_cnt_r <= 32'h0;
      wd_exp_r <= 1'b0;
    end else begin
      wd_exp_r <= 1'b0;
      if (i_hiz_mode) begin
        wd_run_r <= 1'b0;
        wd_cnt_r <= 32'h0;
      end else if (i_host_txn) begin
        wd_run_r <= 1'b1;
        wd_cnt_r <= 32'h0;
      end else if (wd_run_r && tick_r) begin
        if (wd_cnt_r == 32'(WDOG_TICKS_P - 1)) begin
          wd_exp_r <= 1'b1;
          wd_run_r <= 1'b0;
          wd_cnt_r <= 32'h0;
        end else begin
          wd_cnt_r <= wd_cnt_r + 32'h1;
        end
      end
    end
  end

  // safety timer
  assign charge_ok  = i_vin_valid && !i_charge_disable_pin && !cen_n_r;
  assign dur_change = i_host_txn && i_host_wr && (i_wr_duration != dur_r);
  // half-rate steps when another loop dominates
  assign step       = tick_r && (!dte_r || i_loop_cc_cv || half_r);
  // max time = (field+1) units; precharge a tenth of it
  assign safe_lim   = (state_r == csw_pkg::CSW_PRE) ?
                      36'((36'(dur_r) + 36'h1) * 36'(SAFE_UNIT_P) / 36'(csw_pkg::PRECHG_DIV)) :
                      36'((36'(dur_r) + 36'h1) * 36'(SAFE_UNIT_P));

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      half_r <= 1'b0;
    end else if (tick_r) begin
      half_r <= !half_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ok_prev_r <= 1'b0;
    end else begin
      ok_prev_r <= i_vin_valid && !i_charge_disable_pin;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r    <= csw_pkg::CSW_IDLE;
      safe_cnt_r <= 36'h0;
      fault_r    <= 1'b0;
    end else begin
      case (state_r)
        csw_pkg::CSW_IDLE: begin
          safe_cnt_r <= 36'h0;
          if (charge_ok) begin
            state_r <= i_batt_low ? csw_pkg::CSW_PRE : csw_pkg::CSW_FAST;
          end
        end
        csw_pkg::CSW_PRE, csw_pkg::CSW_FAST: begin
          if (!charge_ok || i_terminated) begin
            state_r    <= csw_pkg::CSW_IDLE;
            safe_cnt_r <= 36'h0;
          end else if (dur_change) begin
            safe_cnt_r <= 36'h0;
          end else if (step) begin
            if (safe_cnt_r >= safe_lim - 36'h1) begin
              state_r    <= csw_pkg::CSW_FAULT;
              fault_r    <= 1'b1;
              safe_cnt_r <= 36'h0;
            end else begin
              safe_cnt_r <= safe_cnt_r + 36'h1;
              // expiry outranks the move to fast charge
              if (state_r == csw_pkg::CSW_PRE && !i_batt_low) begin
                state_r <= csw_pkg::CSW_FAST;
              end
            end
          end
        end
        csw_pkg::CSW_FAULT: begin
          // toggle of disable pin or power clears the latch
          if (!(i_vin_valid && !i_charge_disable_pin) && ok_prev_r) begin
            state_r <= csw_pkg::CSW_IDLE;
            fault_r <= 1'b0;
          end
        end
        default: begin
          state_r <= csw_pkg::CSW_IDLE;
        end
      endcase
    end
  end

  // single 128 us interrupt pulse on fault entry
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_cnt_r <= 8'h0;
      o_int_pulse <= 1'b0;
    end else if ((state_r == csw_pkg::CSW_PRE || state_r == csw_pkg::CSW_FAST) && step
                 && safe_cnt_r >= safe_lim - 36'h1 && charge_ok && !i_terminated && !dur_change) begin
      pulse_cnt_r <= 8'(csw_pkg::PULSE_TICKS);
      o_int_pulse <= 1'b1;
    end else if (pulse_cnt_r != 8'h0) begin
      if (tick_r) begin
        pulse_cnt_r <= pulse_cnt_r - 8'h1;
        o_int_pulse <= (pulse_cnt_r != 8'h1);
      end
    end else begin
      o_int_pulse <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_charging     <= 1'b0;
      o_state        <= csw_pkg::CSW_IDLE;
      o_fault        <= 1'b0;
      o_host_mode    <= 1'b0;
      o_wdog_expired <= 1'b0;
      o_pb_fields    <= 4'h0;
    end else begin
      o_charging     <= (state_r == csw_pkg::CSW_PRE) || (state_r == csw_pkg::CSW_FAST);
      o_state        <= state_r;
      o_fault        <= fault_r;
      o_host_mode    <= host_mode_r;
      o_wdog_expired <= wd_exp_r;
      o_pb_fields    <= pb_r;
    end
  end

  assign o_input_limit_resistor_pin_code = input_limit_resistor_pin_out_r;
  assign o_ichg_code = ichg_out_r;

  // assertions
  property p_input_limit_resistor_pin_src;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (host_mode_r || i_input_limit_resistor_pin_gnd) |=> (input_limit_resistor_pin_out_r == $past(input_limit_resistor_pin_reg_r));
  endproperty
  a_input_limit_resistor_pin_src: assert property (p_input_limit_resistor_pin_src) else $error("input limit source wrong");

  property p_ichg_src;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (!host_mode_r && i_charge_current_resistor_pin_gnd) |=> !o_ichg_external;
  endproperty
  a_ichg_src: assert property (p_ichg_src) else $error("charge current source wrong");

  property p_start;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (state_r == csw_pkg::CSW_IDLE && charge_ok) |=> (state_r != csw_pkg::CSW_IDLE && safe_cnt_r == 36'h0);
  endproperty
  a_start: assert property (p_start) else $error("charge did not start");

  property p_fault_stop;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(fault_r) |=> !o_charging;
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("charging after fault");

  property p_int;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(fault_r) |-> o_int_pulse;
  endproperty
  a_int: assert property (p_int) else $error("no interrupt on fault");

  property p_latch;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (fault_r && i_vin_valid && !i_charge_disable_pin) |=> fault_r;
  endproperty
  a_latch: assert property (p_latch) else $error("fault cleared without toggle");

  property p_wd_hiz;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_hiz_mode |=> !wd_run_r;
  endproperty
  a_wd_hiz: assert property (p_wd_hiz) else $error("watchdog ran in hiz");

  property p_wd_restart;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_host_txn && !i_hiz_mode) |=> (wd_run_r && wd_cnt_r == 32'h0);
  endproperty
  a_wd_restart: assert property (p_wd_restart) else $error("watchdog not restarted");

  property p_defaults;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (wd_exp_r && !(i_host_txn && i_host_wr)) |=>
        (input_limit_resistor_pin_reg_r == csw_pkg::INPUT_LIMIT_RESISTOR_PIN_DEF && cen_n_r == csw_pkg::CEN_N_DEF && pb_r == $past(pb_r));
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not restored");

  c_fault: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $rose(fault_r));
  c_wd_exp: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) wd_exp_r);
  c_term: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) state_r == csw_pkg::CSW_FAST && i_terminated);

endmodule // csw_top

// [tb/csw_host_model.sv]
// host controller model: transaction pulses and register writes
`timescale 1ns/1ps
module csw_host_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_keepalive,
  output logic            o_host_txn,
  output logic            o_host_wr,
  output logic [2:0]      o_wr_input_limit_resistor_pin_code,
  output logic [7:0]      o_wr_ichg_code,
  output logic [1:0]      o_wr_duration,
  output logic            o_wr_double_time,
  output logic            o_wr_charge_en_n,
  output logic            o_wr_pb_fields,
  output logic [3:0]      o_wr_pb_value
);
  logic [19:0] sh_r = 20'h00000;
  logic        req_r = 1'b0;
  logic        req_wr_r = 1'b0;
  int          ka_cnt = 0;
  initial begin
    o_host_txn = 1'b0;
    o_host_wr  = 1'b0;
  end
  // data is only meaningful with a write; otherwise show the inverse so stale values never pass
  assign {o_wr_input_limit_resistor_pin_code, o_wr_ichg_code, o_wr_duration, o_wr_double_time, o_wr_charge_en_n,
          o_wr_pb_fields, o_wr_pb_value} = (o_host_txn && o_host_wr) ? sh_r : ~sh_r;
  always @(negedge i_core_clk) begin
    o_host_txn <= 1'b0;
    o_host_wr  <= 1'b0;
    ka_cnt     <= ka_cnt + 1;
    if (req_r) begin
      o_host_txn <= 1'b1;
      o_host_wr  <= req_wr_r;
      req_r      <= 1'b0;
    end else if (i_keepalive && ka_cnt >= 1000) begin
      o_host_txn <= 1'b1;
      ka_cnt     <= 0;
    end
  end
  task automatic txn(input logic wr, input logic [19:0] v);
    sh_r = v;
    req_wr_r = wr;
    req_r = 1'b1;
    wait (req_r == 1'b0);
  endtask
endmodule // csw_host_model

// [tb/tb_top.sv]
// self-checking bench for charge safety timer and host watchdog
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [2:0] lc;
    logic       lg;
    logic [7:0] cc;
    logic       cg;
    logic [2:0] el;
    logic       ele;
    logic [7:0] ec;
    logic       ece;
  } csw_row_s;
  localparam int CYC = csw_pkg::TICK_CYC;
  csw_row_s rows [4] = '{'{3'h5, 1'b1, 8'h44, 1'b1, 3'h1, 1'b0, 8'h0a, 1'b0},
                         '{3'h5, 1'b0, 8'h44, 1'b0, 3'h5, 1'b1, 8'h44, 1'b1},
                         '{3'h6, 1'b1, 8'h21, 1'b0, 3'h1, 1'b0, 8'h21, 1'b1},
                         '{3'h2, 1'b0, 8'h21, 1'b1, 3'h2, 1'b1, 8'h0a, 1'b0}};
  logic       clk = 1'b0, rst_n = 1'b0, ka = 1'b0, lg = 1'b1, cg = 1'b1;
  logic [2:0] lc = 3'h0;
  logic [7:0] cc = 8'h00;
  logic       cd = 1'b0, vin = 1'b1, hiz = 1'b0, term = 1'b0, cccv = 1'b1, blow = 1'b0;
  logic       txn, hwr, w_dbl, w_cen, w_pbw, iext, cext, chg, flt, intp, hm, wdx;
  logic [2:0] w_il, input_limit_resistor_pin;
  logic [7:0] w_ic, ichg;
  logic [1:0] w_dur, st;
  logic [3:0] w_pbv, pb;
  int         err_count = 0, n_tests = 0, pw_cur = 0, pw_last = 0, np = 0, nw = 0;
  always #5 clk = ~clk;
  csw_host_model host_u (.i_core_clk(clk), .i_keepalive(ka), .o_host_txn(txn), .o_host_wr(hwr),
    .o_wr_input_limit_resistor_pin_code(w_il), .o_wr_ichg_code(w_ic), .o_wr_duration(w_dur), .o_wr_double_time(w_dbl),
    .o_wr_charge_en_n(w_cen), .o_wr_pb_fields(w_pbw), .o_wr_pb_value(w_pbv));
  csw_top #(.WDOG_TICKS_P(20), .SAFE_UNIT_P(50)) dut_u (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_host_txn(txn), .i_host_wr(hwr), .i_wr_input_limit_resistor_pin_code(w_il), .i_wr_ichg_code(w_ic),
    .i_wr_duration(w_dur), .i_wr_double_time(w_dbl), .i_wr_charge_en_n(w_cen),
    .i_wr_pb_fields(w_pbw), .i_wr_pb_value(w_pbv), .i_input_limit_resistor_pin_gnd(lg),
    .i_input_limit_resistor_code(lc), .i_charge_current_resistor_pin_gnd(cg),
    .i_charge_current_resistor_code(cc), .i_charge_disable_pin(cd), .i_vin_valid(vin),
    .i_hiz_mode(hiz), .i_terminated(term), .i_loop_cc_cv(cccv), .i_batt_low(blow),
    .o_input_limit_resistor_pin_code(input_limit_resistor_pin), .o_input_limit_resistor_pin_external(iext), .o_ichg_code(ichg), .o_ichg_external(cext),
    .o_charging(chg), .o_state(st), .o_fault(flt), .o_int_pulse(intp), .o_host_mode(hm),
    .o_wdog_expired(wdx), .o_pb_fields(pb));
  always @(negedge clk) begin
    if (wdx === 1'b1) nw++;
    if (intp === 1'b1) pw_cur++;
    else if (pw_cur != 0) begin
      pw_last = pw_cur;
      np++;
      pw_cur = 0;
    end
  end
  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_code(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_us(input int n);
    repeat (n * CYC) @(negedge clk);
  endtask
  task automatic wr(input logic [2:0] il, input logic [7:0] ic, input logic [1:0] d, input logic db,
                    input logic cn, input logic pw, input logic [3:0] pv);
    host_u.txn(1'b1, {il, ic, d, db, cn, pw, pv});
    repeat (5) @(negedge clk);
  endtask
  task automatic clear_fault;
    cd = 1'b1;
    wait_us(2);
    cd = 1'b0;
    wait_us(2);
  endtask
  // scenarios take about 66000 cycles; a hang trips this well before the run limit
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(negedge clk);
    chk_code({5'h00, input_limit_resistor_pin}, 8'h01);
    chk_code(ichg, 8'h0a);
    chk_code({st, chg, flt, intp, hm, wdx, 1'b0}, 8'h00);
    @(negedge clk);
    rst_n = 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      {lc, lg, cc, cg} = {rows[i].lc, rows[i].lg, rows[i].cc, rows[i].cg};
      repeat (5) @(negedge clk);
      chk_code({5'h00, input_limit_resistor_pin}, {5'h00, rows[i].el});
      chk_flag(iext, rows[i].ele);
      chk_code(ichg, rows[i].ec);
      chk_flag(cext, rows[i].ece);
    end
    wait_us(30);
    chk_code(8'(nw), 8'h00);
    $display("test default mode done");
    {lg, lc, cg} = {1'b0, 3'h3, 1'b1};
    wr(3'h7, 8'h33, 2'h0, 1'b0, 1'b1, 1'b1, 4'ha);
    chk_code({5'h00, input_limit_resistor_pin}, 8'h07);
    chk_flag(iext, 1'b0);
    chk_flag(hm, 1'b1);
    chk_code(ichg, 8'h33);
    for (int k = 0; k < 8; k++) begin
      wr(3'(k), 8'h33, 2'h0, 1'b0, 1'b1, 1'b0, 4'h0);
      chk_code({5'h00, input_limit_resistor_pin}, 8'(k));
    end
    ka = 1'b1;
    wait_us(60);
    chk_code(8'(nw), 8'h00);
    ka = 1'b0;
    wait_us(30);
    chk_code(8'(nw), 8'h01);
    chk_flag(hm, 1'b0);
    chk_code({4'h0, iext, input_limit_resistor_pin}, 8'h0b);
    chk_code(ichg, 8'h0a);
    chk_code({4'h0, pb}, 8'h0a);
    wr(3'h1, 8'h33, 2'h0, 1'b0, 1'b1, 1'b0, 4'h0);
    hiz = 1'b1;
    wait_us(30);
    chk_code(8'(nw), 8'h01);
    hiz = 1'b0;
    wait_us(30);
    chk_code(8'(nw), 8'h01);
    host_u.txn(1'b0, 20'h00000);
    wait_us(18);
    chk_code(8'(nw), 8'h01);
    wait_us(4);
    chk_code(8'(nw), 8'h02);
    $display("test watchdog done");
    ka = 1'b1;
    wr(3'h0, 8'h33, 2'h0, 1'b0, 1'b0, 1'b0, 4'h0);
    wait_us(40);
    chk_code({6'h00, st}, 8'h02);
    chk_flag(chg, 1'b1);
    wait_us(20);
    chk_code({6'h00, st}, 8'h03);
    chk_flag(chg, 1'b0);
    chk_flag(flt, 1'b1);
    chk_flag(intp, 1'b1);
    for (int i = 0; i < 20000 && intp === 1'b1; i++) @(negedge clk);
    @(negedge clk);
    chk_code(8'(np), 8'h01);
    chk_code(8'((pw_last + CYC / 2) / CYC), 8'h80);
    chk_flag(flt, 1'b1);
    clear_fault();
    chk_flag(flt, 1'b0);
    blow = 1'b1;
    wr(3'h0, 8'h33, 2'h0, 1'b0, 1'b1, 1'b0, 4'h0);
    wr(3'h0, 8'h33, 2'h0, 1'b0, 1'b0, 1'b0, 4'h0);
    wait_us(3);
    chk_code({6'h00, st}, 8'h01);
    wait_us(5);
    chk_code({6'h00, st}, 8'h03);
    clear_fault();
    $display("test safety timer done");
    blow = 1'b0;
    wr(3'h0, 8'h33, 2'h0, 1'b0, 1'b1, 1'b0, 4'h0);
    wr(3'h0, 8'h33, 2'h0, 1'b0, 1'b0, 1'b0, 4'h0);
    wait_us(40);
    wr(3'h0, 8'h33, 2'h1, 1'b0, 1'b0, 1'b0, 4'h0);
    wait_us(80);
    chk_code({6'h00, st}, 8'h02);
    wait_us(30);
    chk_code({6'h00, st}, 8'h03);
    clear_fault();
    wr(3'h0, 8'h33, 2'h0, 1'b0, 1'b1, 1'b0, 4'h0);
    cccv = 1'b0;
    wr(3'h0, 8'h33, 2'h0, 1'b1, 1'b0, 1'b0, 4'h0);
    wait_us(80);
    chk_code({6'h00, st}, 8'h02);
    wait_us(30);
    chk_code({6'h00, st}, 8'h03);
    $display("test timer restart and half rate done");
    tally_and_finish();
  end
endmodule // tb_top
